// ==== hdl/pin_filter.sv ====
// three-stage pin synchroniser; a change is taken once stages two and three agree
module pin_filter #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] level_q;
  logic [WIDTH-1:0] level_d;

  if (WIDTH < 1) begin : g_check
    $error("pin_filter needs WIDTH of at least 1");
  end

  always_comb begin
    level_d = (s2_q & s3_q) | (level_q & (s2_q | s3_q));
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      level_q <= '0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
    end
  end

  assign level_o = level_q;
endmodule : pin_filter

// ==== hdl/starter_status.sv ====
// run relay and status led driver for a variable speed starter, with axi4-lite registers
// Operation
// - relay closes while any enable is active and no fault exists
// - relay opens at once when any fault becomes active
// - coast stop mode: relay opens as soon as enable goes away
// - ramp stop mode: relay stays closed until ramp reaches zero
// - run led flashes green at 4 Hz when powered, idle, fault free
// - run led steady green while an enable request is active, powered and fault free
// - run led dark without supply or on internal communication fault
// - undervoltage flashes status and code leds red together at 2 Hz
// - fault lights status red; communication fault also lights code red
// - code led blinks fault code count at 2 Hz, then 2 s dark
// - codes 1 to 13 name the fault kinds, overload through data error
// - dc braking lights code led steady yellow when no fault or undervoltage is shown
module starter_status #(
  parameter int unsigned TICK_CYCLES = starter_status_pkg::TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [3:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [3:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic forward_enable_i,
  input wire logic reverse_enable_i,
  input wire logic general_enable_i,
  input wire logic [3:0] fault_code_i,
  input wire logic comm_fault_i,
  input wire logic undervoltage_i,
  input wire logic dc_braking_i,
  input wire logic ramp_at_zero_i,
  input wire logic internal_power_supply_ok_i,
  output logic run_relay_o,
  output logic run_led_green_o,
  output logic status_led_red_o,
  output logic code_led_red_o,
  output logic code_led_yellow_o
);
  localparam int unsigned TICK_W = $clog2(TICK_CYCLES);

  if (TICK_CYCLES < 2) begin : g_check
    $error("starter_status needs TICK_CYCLES of at least 2");
  end

  function automatic logic reg_known(input logic [3:0] addr);
    reg_known = (addr == starter_status_pkg::CONTROL_ADDR) ||
                (addr == starter_status_pkg::STATUS_ADDR);
  endfunction : reg_known

  // pin inputs
  logic [starter_status_pkg::IN_W-1:0] pins;
  logic [starter_status_pkg::IN_W-1:0] lv;
  assign pins = {internal_power_supply_ok_i, ramp_at_zero_i, dc_braking_i, undervoltage_i,
                 comm_fault_i, general_enable_i, reverse_enable_i, forward_enable_i,
                 fault_code_i};

  pin_filter #(.WIDTH(starter_status_pkg::IN_W)) u_pins (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .pin_i(pins),
    .level_o(lv)
  );

  logic [3:0] code;
  logic enable_any;
  logic comm_fault;
  logic undervolt;
  logic dc_brake;
  logic ramp_zero;
  logic power_ok;
  logic fault_act;
  assign code = lv[3:0];
  assign enable_any = lv[4] | lv[5] | lv[6];
  assign comm_fault = lv[7];
  assign undervolt = lv[8];
  assign dc_brake = lv[9];
  assign ramp_zero = lv[10];
  assign power_ok = lv[11];
  assign fault_act = (code != starter_status_pkg::CODE_NONE) | comm_fault;

  // blink phase generator
  logic [TICK_W-1:0] tick_cnt_q, tick_cnt_d;
  logic tick_q, tick_d;
  logic fast_q, fast_d;
  logic slow_q, slow_d;

  always_comb begin
    tick_d = (tick_cnt_q == TICK_W'(TICK_CYCLES - 1));
    tick_cnt_d = tick_d ? '0 : tick_cnt_q + TICK_W'(1);
    fast_d = fast_q ^ tick_q;
    slow_d = slow_q ^ (tick_q & fast_q);
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
      fast_q <= 1'b0;
      slow_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      tick_q <= tick_d;
      fast_q <= fast_d;
      slow_q <= slow_d;
    end
  end

  // fault code burst sequencer
  starter_status_pkg::blink_state_t blink_q, blink_d;
  logic [4:0] left_q, left_d;
  logic [3:0] pulses_q, pulses_d;

  always_comb begin
    blink_d = blink_q;
    left_d = left_q;
    pulses_d = pulses_q;
    if (code == starter_status_pkg::CODE_NONE) begin
      blink_d = starter_status_pkg::BLINK_IDLE;
    end else begin
      unique case (blink_q)
        starter_status_pkg::BLINK_IDLE: begin
          blink_d = starter_status_pkg::BLINK_ON;
          left_d = starter_status_pkg::SLOW_TICKS;
          pulses_d = starter_status_pkg::CODE_FIRST;
        end
        starter_status_pkg::BLINK_ON: begin
          if (tick_q && left_q == 5'h01) begin
            if (pulses_q >= code) begin
              blink_d = starter_status_pkg::BLINK_PAUSE;
              left_d = starter_status_pkg::PAUSE_TICKS;
            end else begin
              blink_d = starter_status_pkg::BLINK_OFF;
              left_d = starter_status_pkg::SLOW_TICKS;
            end
          end else if (tick_q) begin
            left_d = left_q - 5'h01;
          end
        end
        starter_status_pkg::BLINK_OFF, starter_status_pkg::BLINK_PAUSE: begin
          if (tick_q && left_q == 5'h01 && blink_q == starter_status_pkg::BLINK_OFF &&
              pulses_q >= code) begin
            // code lowered mid-burst: cut the burst short instead of overrunning it
            blink_d = starter_status_pkg::BLINK_PAUSE;
            left_d = starter_status_pkg::PAUSE_TICKS;
          end else if (tick_q && left_q == 5'h01) begin
            blink_d = starter_status_pkg::BLINK_ON;
            left_d = starter_status_pkg::SLOW_TICKS;
            pulses_d = (blink_q == starter_status_pkg::BLINK_OFF) ?
                       pulses_q + 4'h1 : starter_status_pkg::CODE_FIRST;
          end else if (tick_q) begin
            left_d = left_q - 5'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      blink_q <= starter_status_pkg::BLINK_IDLE;
      left_q <= '0;
      pulses_q <= '0;
    end else begin
      blink_q <= blink_d;
      left_q <= left_d;
      pulses_q <= pulses_d;
    end
  end

  // relay and led outputs
  logic stop_ramp_q;
  logic relay_q, relay_d;
  logic run_led_q, run_led_d;
  logic status_q, status_d;
  logic code_red_q, code_red_d;
  logic yellow_q, yellow_d;

  always_comb begin
    if (fault_act) begin
      relay_d = 1'b0;
    end else if (enable_any) begin
      relay_d = 1'b1;
    end else if (stop_ramp_q) begin
      relay_d = relay_q & ~ramp_zero;
    end else begin
      relay_d = 1'b0;
    end
    if (!power_ok || fault_act) begin
      run_led_d = 1'b0;
    end else if (enable_any) begin
      run_led_d = 1'b1;
    end else begin
      run_led_d = fast_q;
    end
    yellow_d = 1'b0;
    if (undervolt) begin
      status_d = slow_q;
      code_red_d = slow_q;
    end else if (fault_act) begin
      status_d = 1'b1;
      code_red_d = comm_fault | (blink_q == starter_status_pkg::BLINK_ON);
    end else begin
      status_d = 1'b0;
      code_red_d = 1'b0;
      yellow_d = dc_brake;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      relay_q <= 1'b0;
      run_led_q <= 1'b0;
      status_q <= 1'b0;
      code_red_q <= 1'b0;
      yellow_q <= 1'b0;
    end else begin
      relay_q <= relay_d;
      run_led_q <= run_led_d;
      status_q <= status_d;
      code_red_q <= code_red_d;
      yellow_q <= yellow_d;
    end
  end

  assign run_relay_o = relay_q;
  assign run_led_green_o = run_led_q;
  assign status_led_red_o = status_q;
  assign code_led_red_o = code_red_q;
  assign code_led_yellow_o = yellow_q;

  // axi4-lite slave
  logic aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic [3:0] waddr_q, waddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic stop_ramp_d;
  logic aw_take, w_take, do_write, ar_take;
  logic [31:0] status_word;

  always_comb begin
    status_word = '0;
    status_word[starter_status_pkg::ST_RELAY_BIT] = relay_q;
    status_word[starter_status_pkg::ST_RUN_LED_BIT] = run_led_q;
    status_word[starter_status_pkg::ST_STATUS_LED_BIT] = status_q;
    status_word[starter_status_pkg::ST_CODE_RED_BIT] = code_red_q;
    status_word[starter_status_pkg::ST_CODE_YELLOW_BIT] = yellow_q;
    status_word[starter_status_pkg::ST_CODE_LSB +: 4] = code;
    status_word[starter_status_pkg::ST_UNDERVOLT_BIT] = undervolt;
    status_word[starter_status_pkg::ST_DC_BRAKE_BIT] = dc_brake;
    status_word[starter_status_pkg::ST_COMM_FAULT_BIT] = comm_fault;
    status_word[starter_status_pkg::ST_ENABLE_BIT] = enable_any;
    aw_take = s_axi_awvalid_i & awready_q;
    w_take = s_axi_wvalid_i & wready_q;
    aw_held_d = aw_held_q | aw_take;
    w_held_d = w_held_q | w_take;
    waddr_d = aw_take ? s_axi_awaddr_i : waddr_q;
    wdata_d = w_take ? s_axi_wdata_i : wdata_q;
    wstrb_d = w_take ? s_axi_wstrb_i : wstrb_q;
    do_write = aw_held_d & w_held_d & ~bvalid_q;
    stop_ramp_d = stop_ramp_q;
    bvalid_d = bvalid_q & ~s_axi_bready_i;
    bresp_d = bresp_q;
    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = reg_known(waddr_d) ? starter_status_pkg::RESP_OKAY :
                starter_status_pkg::RESP_SLVERR;
      if (waddr_d == starter_status_pkg::CONTROL_ADDR && wstrb_d[0]) begin
        stop_ramp_d = wdata_d[starter_status_pkg::CTRL_STOP_RAMP_BIT];
      end
    end
    awready_d = ~aw_held_d & ~bvalid_d;
    wready_d = ~w_held_d & ~bvalid_d;
    ar_take = s_axi_arvalid_i & arready_q;
    rvalid_d = rvalid_q & ~s_axi_rready_i;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (ar_take) begin
      rvalid_d = 1'b1;
      rresp_d = reg_known(s_axi_araddr_i) ? starter_status_pkg::RESP_OKAY :
                starter_status_pkg::RESP_SLVERR;
      if (s_axi_araddr_i == starter_status_pkg::CONTROL_ADDR) begin
        rdata_d = {31'h0, stop_ramp_q};
      end else if (s_axi_araddr_i == starter_status_pkg::STATUS_ADDR) begin
        rdata_d = status_word;
      end else begin
        rdata_d = '0;
      end
    end
    arready_d = ~rvalid_d;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= starter_status_pkg::RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= starter_status_pkg::RESP_OKAY;
      stop_ramp_q <= starter_status_pkg::CTRL_STOP_RAMP_RESET;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      stop_ramp_q <= stop_ramp_d;
    end
  end

  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o = wready_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_relay_on_enable: assert property (enable_any && !fault_act |=> run_relay_o)
    else $error("relay not closed while enabled");
  a_relay_fault_open: assert property (fault_act |=> !run_relay_o)
    else $error("relay closed during fault");
  a_relay_coast_open: assert property (!enable_any && !stop_ramp_q |=> !run_relay_o)
    else $error("relay closed after coast stop");
  a_relay_ramp_hold: assert property (run_relay_o && !enable_any && stop_ramp_q && !ramp_zero
    && !fault_act |=> run_relay_o)
    else $error("relay opened before ramp end");
  a_run_idle_flash: assert property (power_ok && !enable_any && !fault_act && tick_q
    ##1 power_ok && !enable_any && !fault_act |=> run_led_green_o != $past(run_led_green_o))
    else $error("run led not flashing when idle");
  a_run_steady: assert property (power_ok && enable_any && !fault_act |=> run_led_green_o)
    else $error("run led not steady while running");
  a_run_dark: assert property (!power_ok || comm_fault |=> !run_led_green_o)
    else $error("run led lit without supply");
  a_undervolt_pair: assert property (undervolt |=> status_led_red_o == code_led_red_o
    && status_led_red_o == $past(slow_q))
    else $error("undervoltage leds not paired");
  a_fault_status: assert property (fault_act && !undervolt |=> status_led_red_o
    && (!comm_fault || code_led_red_o))
    else $error("fault status led not lit");
  a_burst_count: assert property (blink_q == starter_status_pkg::BLINK_ON
    && $past(blink_q) == starter_status_pkg::BLINK_OFF |-> pulses_q <= code)
    else $error("fault burst longer than code");
  a_brake_yellow: assert property (dc_brake && !fault_act && !undervolt
    |=> code_led_yellow_o && !code_led_red_o)
    else $error("braking not shown yellow");
endmodule : starter_status

// ==== hdl/starter_status_pkg.sv ====
// constants and types for the starter status indication block
package starter_status_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  // base blink phase: every pattern is built from whole phases
  localparam int unsigned TICK_MS = 125;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  // 2 Hz blink: half period of 250 ms in phases
  localparam int unsigned SLOW_HALF_MS = 250;
  localparam logic [4:0] SLOW_TICKS = 5'(SLOW_HALF_MS / TICK_MS);
  // dark pause after a fault code burst
  localparam int unsigned PAUSE_MS = 2000;
  localparam logic [4:0] PAUSE_TICKS = 5'(PAUSE_MS / TICK_MS);

  localparam logic [3:0] CODE_NONE = 4'h0;
  localparam logic [3:0] CODE_FIRST = 4'h1;

  // register map, byte addresses
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] CONTROL_ADDR = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h4;
  localparam int unsigned CTRL_STOP_RAMP_BIT = 0;
  localparam logic CTRL_STOP_RAMP_RESET = 1'b0;

  localparam int unsigned ST_RELAY_BIT = 0;
  localparam int unsigned ST_RUN_LED_BIT = 1;
  localparam int unsigned ST_STATUS_LED_BIT = 2;
  localparam int unsigned ST_CODE_RED_BIT = 3;
  localparam int unsigned ST_CODE_YELLOW_BIT = 4;
  localparam int unsigned ST_CODE_LSB = 8;
  localparam int unsigned ST_UNDERVOLT_BIT = 12;
  localparam int unsigned ST_DC_BRAKE_BIT = 13;
  localparam int unsigned ST_COMM_FAULT_BIT = 14;
  localparam int unsigned ST_ENABLE_BIT = 15;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // input vector layout after the synchroniser
  localparam int unsigned IN_W = 12;

  typedef enum logic [1:0] {BLINK_IDLE, BLINK_ON, BLINK_OFF, BLINK_PAUSE} blink_state_t;
endpackage : starter_status_pkg

// ==== verification/led_panel_model.sv ====
// led panel observer: counts the pulses of each fault code burst on the red code led
module led_panel_model #(
  parameter int GAP_CYCLES = 64
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic code_led_red_i,
  output logic [4:0] burst_count_o,
  output logic burst_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev_q;
  logic [4:0] cnt_q;
  int dark_q;

  // count pulses, close burst on long dark
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prev_q <= 1'b0;
      cnt_q <= 5'h00;
      dark_q <= 0;
      burst_count_o <= 5'h00;
      burst_valid_o <= 1'b0;
    end else begin
      prev_q <= code_led_red_i;
      burst_valid_o <= 1'b0;
      if (code_led_red_i && !prev_q) cnt_q <= cnt_q + 5'h01;
      if (code_led_red_i) dark_q <= 0;
      else if (dark_q != GAP_CYCLES) dark_q <= dark_q + 1;
      if (dark_q == GAP_CYCLES - 1 && !code_led_red_i && cnt_q != 5'h00) begin
        burst_count_o <= cnt_q;
        burst_valid_o <= 1'b1;
        cnt_q <= 5'h00;
      end
    end
  end
endmodule : led_panel_model

// ==== verification/test_starter_status.sv ====
// self-checking bench for the starter status block
`define check(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module test_starter_status;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF, fault_code = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [2:0] en = 3'h0;
  logic comm = 1'b0, uv = 1'b0, dcb = 1'b0, ramp0 = 1'b1, supply = 1'b1;
  logic relay, run_led, st_red, code_red, code_yel, bvalid_m;
  logic [4:0] bcount;
  logic [7:0] rnd = 8'h62;
  int num_errors = 0, checks_done = 0, cyc = 0, tg;
  localparam int TICK = 8;

  always #12.5 clk_i = ~clk_i;

  starter_status #(.TICK_CYCLES(TICK)) starter_status_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .forward_enable_i(en[0]),
    .reverse_enable_i(en[1]), .general_enable_i(en[2]), .fault_code_i(fault_code),
    .comm_fault_i(comm), .undervoltage_i(uv), .dc_braking_i(dcb), .ramp_at_zero_i(ramp0),
    .internal_power_supply_ok_i(supply), .run_relay_o(relay), .run_led_green_o(run_led),
    .status_led_red_o(st_red), .code_led_red_o(code_red), .code_led_yellow_o(code_yel));

  led_panel_model #(.GAP_CYCLES(64)) led_panel_model_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .code_led_red_i(code_red), .burst_count_o(bcount), .burst_valid_o(bvalid_m));

  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr_next

  // steady burst repeat time in cycles: pulses, gaps between them, then the pause
  function automatic int burst_period(input int c);
    return ((2 * c - 1) * int'(starter_status_pkg::SLOW_TICKS) +
            int'(starter_status_pkg::PAUSE_TICKS)) * TICK;
  endfunction : burst_period

  task automatic end_of_test();
    if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wait_cycles

  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] er);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw || w) begin
      @(posedge clk_i);
      if (aw && awready) begin aw = 1'b0; awvalid <= 1'b0; end
      if (w && wready) begin w = 1'b0; wvalid <= 1'b0; end
    end
    while (bvalid !== 1'b1) @(posedge clk_i);
    `check(bresp, er)
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_i); while (rvalid !== 1'b1);
    d = rdata;
    `check(rresp, er)
    rready <= 1'b0;
  endtask : axi_read

  // counts toggles of the run led (sel 0) or status led (sel 1) over n cycles
  task automatic count_toggles(input int n, input bit sel);
    logic last;
    tg = 0;
    last = sel ? st_red : run_led;
    repeat (n) begin
      @(posedge clk_i);
      if ((sel ? st_red : run_led) !== last) tg++;
      last = sel ? st_red : run_led;
      if (sel) `check(code_red, st_red)
    end
  endtask : count_toggles

  initial begin
    logic [31:0] d;
    int n;
    wait_cycles(4);
    `check({relay, run_led, st_red, code_red, code_yel}, 5'h00)
    wait_cycles(4);
    reset_n_i <= 1'b1;
    wait_cycles(8);
    count_toggles(48, 1'b0);
    `check(tg >= 4, 1'b1)
    `check(relay, 1'b0)
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr_next(rnd);
      en <= 3'(1 << ((i + rnd[0]) % 3));
      wait_cycles(8);
      `check({relay, run_led}, 2'b11)
      axi_read(starter_status_pkg::STATUS_ADDR, d, starter_status_pkg::RESP_OKAY);
      `check({d[15], d[1:0]}, 3'b111)
      en <= 3'h0;
      wait_cycles(8);
      `check(relay, 1'b0)
    end
    rnd = lfsr_next(rnd);
    axi_write(starter_status_pkg::CONTROL_ADDR, {24'h0, rnd[7:1], 1'b1}, 4'hF,
              starter_status_pkg::RESP_OKAY);
    axi_write(starter_status_pkg::CONTROL_ADDR, 32'h0, 4'h0, starter_status_pkg::RESP_OKAY);
    axi_read(starter_status_pkg::CONTROL_ADDR, d, starter_status_pkg::RESP_OKAY);
    `check(d[0], 1'b1)
    ramp0 <= 1'b0;
    en <= 3'h1;
    wait_cycles(8);
    en <= 3'h0;
    wait_cycles(20);
    `check(relay, 1'b1)
    ramp0 <= 1'b1;
    wait_cycles(8);
    `check(relay, 1'b0)
    en <= 3'h2;
    wait_cycles(8);
    `check(relay, 1'b1)
    reset_n_i <= 1'b0;
    wait_cycles(2);
    `check({relay, run_led, st_red, code_red, code_yel}, 5'h00)
    reset_n_i <= 1'b1;
    wait_cycles(8);
    `check({relay, run_led}, 2'b11)
    axi_read(starter_status_pkg::CONTROL_ADDR, d, starter_status_pkg::RESP_OKAY);
    `check(d[0], starter_status_pkg::CTRL_STOP_RAMP_RESET)
    ramp0 <= 1'b0;
    en <= 3'h0;
    wait_cycles(8);
    `check(relay, 1'b0)
    ramp0 <= 1'b1;
    axi_write(starter_status_pkg::CONTROL_ADDR, 32'h0, 4'hF, starter_status_pkg::RESP_OKAY);
    axi_write(4'h8, 32'hFFFF_FFFF, 4'hF, starter_status_pkg::RESP_SLVERR);
    axi_write(starter_status_pkg::STATUS_ADDR, 32'h1, 4'hF, starter_status_pkg::RESP_OKAY);
    axi_read(4'hC, d, starter_status_pkg::RESP_SLVERR);
    `check(d, 32'h0)
    en <= 3'h4;
    for (int c = 1; c <= 13; c++) begin
      fault_code <= 4'h0;
      wait_cycles(200);
      fault_code <= 4'(c);
      wait_cycles(8);
      `check({relay, run_led, st_red}, 3'b001)
      n = 0;
      do begin @(posedge clk_i); n++; end while (bvalid_m !== 1'b1 && n < 2000);
      `check(bcount, 5'(c))
      n = 0;
      do begin @(posedge clk_i); n++; end while (bvalid_m !== 1'b1 && n < 2000);
      `check(n, burst_period(c))
    end
    fault_code <= 4'h5;
    uv <= 1'b1;
    wait_cycles(8);
    count_toggles(80, 1'b1);
    `check(tg >= 4, 1'b1)
    uv <= 1'b0;
    fault_code <= 4'h0;
    comm <= 1'b1;
    wait_cycles(8);
    `check({relay, run_led, st_red, code_red}, 4'b0011)
    comm <= 1'b0;
    en <= 3'h0;
    dcb <= 1'b1;
    wait_cycles(8);
    `check(code_yel, 1'b1)
    dcb <= 1'b0;
    supply <= 1'b0;
    wait_cycles(8);
    count_toggles(40, 1'b0);
    `check({tg == 0, run_led}, 2'b10)
    end_of_test();
  end
endmodule : test_starter_status
